/* File: hdl/dsl_pkg.sv */
// constants and types of the digital setpoint input latch
// What this block does
// [RL1] sixteen parallel setpoint lines, decoded as BCD or binary by configuration
// [RL2] BCD mode: three digits up to 999, or four digits up to 9999
// [RL3] narrow binary: lines 0 to 11 only, unsigned, maximum FFF hex
// [RL4] wide binary: all sixteen lines, unsigned, maximum FFFF hex
// [RL5] read timing select equal to 1: sample only while strobe is active
// [RL6] strobe inactive: hold the last word sampled before it dropped
// [RL7] active level follows the drive's sink/source selection, tracking changes
// [RL8] far side drives strobe and holds data stable while strobe is active
// [RL9] BCD: four lines per digit, line 0 weight one, ones to thousands
// [RL10] BCD digit above nine rejects the word, previous value kept
// [RL11] input enable select of 9999 disables capture entirely
// [RL12] binary: word taken as hexadecimal, line 0 least significant
// [RL13] read timing select not 1: sample every cycle regardless of strobe
package dsl_pkg;
    localparam logic [31:0] ADDR_CTRL      = 32'h0000_0000;
    localparam logic [31:0] ADDR_INPUT_EN  = 32'h0000_0004;
    localparam logic [31:0] ADDR_TIMING    = 32'h0000_0008;
    localparam logic [31:0] ADDR_VALUE     = 32'h0000_000C;
    localparam logic [31:0] ADDR_RAW       = 32'h0000_0010;
    localparam logic [31:0] ADDR_STATUS    = 32'h0000_0014;
    // control register fields
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_SOURCE_BIT = 2;
    localparam logic [1:0]  MODE_BCD3      = 2'h0;
    localparam logic [1:0]  MODE_BCD4      = 2'h1;
    localparam logic [1:0]  MODE_BIN12     = 2'h2;
    localparam logic [1:0]  MODE_BIN16     = 2'h3;
    localparam logic [2:0]  CTRL_RESET     = 3'h0;
    localparam logic [15:0] INPUT_EN_OFF   = 16'h270F;
    localparam logic [15:0] INPUT_EN_RESET = 16'h270F;
    localparam logic [15:0] TIMING_STROBED = 16'h0001;
    localparam logic [15:0] TIMING_RESET   = 16'h0000;
    localparam logic [15:0] VALUE_RESET    = 16'h0000;
    localparam logic [3:0]  DIGIT_MAX      = 4'h9;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
    // status bits
    localparam int          STAT_REJECT_BIT = 0;
    localparam int          STAT_ENABLE_BIT = 1;
    localparam int          STAT_SAMPLE_BIT = 2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } dsl_bus_state_t;

    function automatic logic [13:0] dsl_bcd_value(input logic [15:0] w, input logic four);
        logic [13:0] v;
        v = 14'(w[3:0]) + 14'(w[7:4]) * 14'h000A + 14'(w[11:8]) * 14'h0064;
        if (four) begin
            v = v + 14'(w[15:12]) * 14'h03E8;
        end
        return v;
    endfunction

    function automatic logic dsl_digit_bad(input logic [3:0] d);
        return d > DIGIT_MAX;
    endfunction
endpackage

/* File: hdl/dsl_if.sv */
// sampled word carried from the input stage to the decoder
`timescale 1ns/100ps
interface dsl_if;
    logic [15:0] word;
    logic        take;
    modport src (output word, output take);
    modport dst (input word, input take);
endinterface

/* File: hdl/dsl_sampler.sv */
// input stage: level correction and sample timing of the setpoint lines
`timescale 1ns/100ps
module dsl_sampler import dsl_pkg::*; (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // pins and configuration
    input  wire logic [15:0] setpointLines,
    input  wire logic        captureStrobe,
    input  wire logic        sourceLogic,
    input  wire logic        strobedMode,
    input  wire logic        enabled,
    // to the decoder
    dsl_if.src               smp
);
    logic [15:0] word_q;
    logic        take_q;
    logic        strobeOn;

    // sink logic: line pulled low means on; source: high means on
    assign strobeOn = sourceLogic ? captureStrobe : ~captureStrobe; // RL7

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            word_q <= VALUE_RESET;
            take_q <= 1'b0;
        end else if (clkEn) begin
            word_q <= sourceLogic ? setpointLines : ~setpointLines; // RL7
            // held word lives downstream; no take means frozen
            take_q <= enabled && (!strobedMode || strobeOn); // RL5 RL6 RL11 RL13
        end
    end

    assign smp.word = word_q;
    assign smp.take = take_q;

    property p_take_needs_strobe;
        @(posedge clk_sys) disable iff (reset)
        clkEn && strobedMode && !strobeOn |=> !take_q;
    endproperty
    a_take_needs_strobe: assert property (p_take_needs_strobe) // RL5
        else $error("sample taken with strobe inactive");

    property p_take_free_run;
        @(posedge clk_sys) disable iff (reset)
        clkEn && !strobedMode && enabled |=> take_q;
    endproperty
    a_take_free_run: assert property (p_take_free_run) // RL13
        else $error("free-running sample missed");

    property p_disabled_no_take;
        @(posedge clk_sys) disable iff (reset)
        clkEn && !enabled |=> !take_q;
    endproperty
    a_disabled_no_take: assert property (p_disabled_no_take) // RL11
        else $error("sample taken while disabled");

    property p_level_follow;
        @(posedge clk_sys) disable iff (reset)
        clkEn |=> word_q == (($past(sourceLogic)) ? $past(setpointLines) : ~$past(setpointLines));
    endproperty
    a_level_follow: assert property (p_level_follow) // RL7
        else $error("active level not applied");
endmodule // dsl_sampler

/* File: hdl/dsl_setpoint_latch.sv */
// top: wishbone register file and setpoint decode/hold
`timescale 1ns/100ps
module dsl_setpoint_latch import dsl_pkg::*; (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // setpoint pins
    input  wire logic [15:0] setpointLines,
    input  wire logic        captureStrobe,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // decoded setpoint
    output logic      [15:0] setpointValue,
    output logic             setpointUpdate
);
    dsl_if smp ();

    logic [2:0]     ctrl_q;
    logic [15:0]    inputEn_q;
    logic [15:0]    timing_q;
    logic [15:0]    value_q;
    logic [15:0]    raw_q;
    logic           reject_q;
    logic           update_q;
    logic [31:0]    rdat_q;
    logic           ack_q;
    dsl_bus_state_t bus_q;
    logic [1:0]     mode;
    logic           wordBad;
    logic [15:0]    decoded;
    logic           busReq;
    logic           busWr;

    assign mode = ctrl_q[CTRL_MODE_LSB +: 2];

    dsl_sampler dsl_sampler_inst (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .clkEn         (clkEn),
        .setpointLines (setpointLines),
        .captureStrobe (captureStrobe),
        .sourceLogic   (ctrl_q[CTRL_SOURCE_BIT]),
        .strobedMode   (timing_q == TIMING_STROBED),
        .enabled       (inputEn_q != INPUT_EN_OFF),
        .smp           (smp.src)
    );

    // decode of the sampled word
    always_comb begin
        wordBad = 1'b0;
        decoded = VALUE_RESET;
        case (mode)
            MODE_BCD3: begin
                wordBad = dsl_digit_bad(smp.word[3:0]) || dsl_digit_bad(smp.word[7:4])
                       || dsl_digit_bad(smp.word[11:8]); // RL10
                decoded = {2'h0, dsl_bcd_value(smp.word, 1'b0)}; // RL2 RL9
            end
            MODE_BCD4: begin
                wordBad = dsl_digit_bad(smp.word[3:0]) || dsl_digit_bad(smp.word[7:4])
                       || dsl_digit_bad(smp.word[11:8])
                       || dsl_digit_bad(smp.word[15:12]); // RL10
                decoded = {2'h0, dsl_bcd_value(smp.word, 1'b1)}; // RL2 RL9
            end
            MODE_BIN12: decoded = {4'h0, smp.word[11:0]}; // RL3 RL12
            MODE_BIN16: decoded = smp.word; // RL4 RL12
            default: decoded = VALUE_RESET;
        endcase
    end

    // accepted value; held between takes and on a bad BCD word
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            value_q  <= VALUE_RESET;
            raw_q    <= VALUE_RESET;
            update_q <= 1'b0;
        end else if (clkEn) begin
            update_q <= 1'b0;
            if (smp.take) begin
                raw_q <= smp.word;
                if (!wordBad) begin
                    value_q  <= decoded; // RL1 RL6 RL10
                    update_q <= 1'b1;
                end
            end
        end
    end

    assign busReq = wb_cyc_i && wb_stb_i && (bus_q == BUS_IDLE);
    // writes land at the edge where the master sees ack, request still held
    assign busWr  = wb_cyc_i && wb_stb_i && wb_we_i && (bus_q == BUS_ACK);

    // reject flag: sticky, cleared by writing 1; a new reject wins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reject_q <= 1'b0;
        end else if (clkEn) begin
            if (smp.take && wordBad) begin
                reject_q <= 1'b1;
            end else if (busWr && wb_adr_i == ADDR_STATUS && wb_sel_i[0]
                         && wb_dat_i[STAT_REJECT_BIT]) begin
                reject_q <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_q    <= CTRL_RESET;
            inputEn_q <= INPUT_EN_RESET;
            timing_q  <= TIMING_RESET;
        end else if (clkEn && busWr) begin
            case (wb_adr_i)
                ADDR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        ctrl_q <= wb_dat_i[2:0];
                    end
                end
                ADDR_INPUT_EN: begin
                    if (wb_sel_i[0]) begin
                        inputEn_q[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        inputEn_q[15:8] <= wb_dat_i[15:8];
                    end
                end
                ADDR_TIMING: begin
                    if (wb_sel_i[0]) begin
                        timing_q[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        timing_q[15:8] <= wb_dat_i[15:8];
                    end
                end
                default: ;
            endcase
        end
    end

    // bus handshake: ack one cycle after the request, then one idle cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bus_q  <= BUS_IDLE;
            ack_q  <= 1'b0;
            rdat_q <= UNMAPPED_DATA;
        end else if (clkEn) begin
            case (bus_q)
                BUS_IDLE: begin
                    ack_q <= busReq;
                    if (busReq) begin
                        bus_q <= BUS_ACK;
                        case (wb_adr_i)
                            ADDR_CTRL:     rdat_q <= {29'h0, ctrl_q};
                            ADDR_INPUT_EN: rdat_q <= {16'h0, inputEn_q};
                            ADDR_TIMING:   rdat_q <= {16'h0, timing_q};
                            ADDR_VALUE:    rdat_q <= {16'h0, value_q};
                            ADDR_RAW:      rdat_q <= {16'h0, raw_q};
                            ADDR_STATUS:   rdat_q <= {29'h0, smp.take,
                                                      inputEn_q != INPUT_EN_OFF, reject_q};
                            default:       rdat_q <= UNMAPPED_DATA;
                        endcase
                    end
                end
                BUS_ACK: begin
                    ack_q <= 1'b0;
                    bus_q <= BUS_IDLE;
                end
                default: begin
                    ack_q <= 1'b0;
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    assign wb_dat_o       = rdat_q;
    assign wb_ack_o       = ack_q;
    assign setpointValue  = value_q;
    assign setpointUpdate = update_q;

    sequence s_bad_take;
        clkEn && smp.take && wordBad;
    endsequence

    property p_reject_holds;
        @(posedge clk_sys) disable iff (reset)
        s_bad_take |=> $stable(value_q) && reject_q;
    endproperty
    a_reject_holds: assert property (p_reject_holds) // RL10
        else $error("bad BCD word changed the setpoint");

    property p_hold_without_take;
        @(posedge clk_sys) disable iff (reset)
        !smp.take |=> $stable(value_q);
    endproperty
    a_hold_without_take: assert property (p_hold_without_take) // RL6
        else $error("setpoint changed without a sample");

    property p_bcd_range;
        @(posedge clk_sys) disable iff (reset)
        mode == MODE_BCD3 && $stable(mode) |-> value_q <= 16'h03E7 || $changed(value_q) == 0;
    endproperty
    a_bcd_range: assert property (p_bcd_range) // RL2
        else $error("three-digit setpoint above 999");

    property p_bin12;
        @(posedge clk_sys) disable iff (reset)
        clkEn && smp.take && mode == MODE_BIN12 |=> value_q == {4'h0, $past(smp.word[11:0])};
    endproperty
    a_bin12: assert property (p_bin12) // RL3
        else $error("narrow binary value wrong");

    property p_ack_one;
        @(posedge clk_sys) disable iff (reset)
        clkEn && busReq ##1 clkEn |-> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack not a single cycle after request");
endmodule // dsl_setpoint_latch

/* File: verif/dsl_contact_model.sv */
// far-side model: relay contacts or open-collector outputs driving the setpoint pins
`timescale 1ns/100ps
module dsl_contact_model (
    // contact states, one bit per line, 1 = contact on
    input  wire logic        sourceLogic,
    input  wire logic [15:0] onWord,
    input  wire logic        strobeOn,
    // pins seen by the drive
    output logic      [15:0] setpointLines,
    output logic             captureStrobe
);
    // sink wiring pulls an open contact high, so on reads low
    assign setpointLines = sourceLogic ? onWord : ~onWord;
    assign captureStrobe = sourceLogic ? strobeOn : ~strobeOn;
endmodule // dsl_contact_model

/* File: verif/dsl_setpoint_latch_tb.sv */
// self-checking bench of the setpoint latch
`timescale 1ns/100ps
module dsl_setpoint_latch_tb import dsl_pkg::*;;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        wbCyc   = 1'b0;
    logic        wbStb   = 1'b0;
    logic        wbWe    = 1'b0;
    logic [31:0] wbAdr   = 32'h0;
    logic [31:0] wbDatI  = 32'h0;
    logic [3:0]  wbSel   = 4'h0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic [15:0] pins;
    logic [15:0] onWord  = 16'h0;
    logic [15:0] setpointValue;
    logic        strobePin;
    logic        strobeOn = 1'b0;
    logic        srcLogic = 1'b0;
    logic        clkEn    = 1'b1;
    logic        setpointUpdate;
    logic [31:0] rd;
    int          nFail = 0;
    int          samplesChecked = 0;
    int          nUpd = 0;
    int          u;

    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (setpointUpdate === 1'b1) nUpd <= nUpd + 1;

    dsl_contact_model dsl_contact_model_inst (
        .sourceLogic(srcLogic), .onWord(onWord), .strobeOn(strobeOn),
        .setpointLines(pins), .captureStrobe(strobePin));

    dsl_setpoint_latch dsl_setpoint_latch_inst (
        .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
        .setpointLines(pins), .captureStrobe(strobePin),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatI), .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .setpointValue(setpointValue), .setpointUpdate(setpointUpdate));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // entered at a rising edge; waits for ack, bounded
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= adr; wbDatI <= wd; wbSel <= 4'hF;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        chk("wb_ack_o", 32'h1, {31'h0, wbAck});
        rd = wbDatO;
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdchk(input string nm, input logic [31:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(nm, exp, rd);
    endtask

    // pin to output takes two edges; sampled at the third
    task automatic put(input logic [15:0] w, input logic [15:0] exp);
        onWord <= w;
        repeat (3) @(posedge clk_sys);
        chk("setpointValue", {16'h0, exp}, {16'h0, setpointValue});
    endtask

    task automatic t_reset();
        rdchk("ctrl", ADDR_CTRL, 32'h0);
        rdchk("input_en", ADDR_INPUT_EN, 32'h270F);
        rdchk("timing", ADDR_TIMING, 32'h0);
        rdchk("unmapped", 32'h0000_0020, 32'h0);
        u = nUpd;
        put(16'h0005, 16'h0000);
        chk("updates while disabled", u, nUpd);
        $display("test reset done");
    endtask

    task automatic t_bcd();
        wb(1'b1, ADDR_INPUT_EN, 32'h0);
        wb(1'b1, ADDR_CTRL, {30'h0, MODE_BCD4});
        u = nUpd;
        put(16'h6325, 16'd6325);
        chk("updates when enabled", 32'h1, {31'h0, nUpd > u});
        put(16'h9999, 16'd9999);
        wb(1'b1, ADDR_CTRL, {30'h0, MODE_BCD3});
        put(16'h7999, 16'd999);
        put(16'h0000, 16'd0);
        $display("test bcd done");
    endtask

    task automatic t_reject();
        wb(1'b1, ADDR_CTRL, {30'h0, MODE_BCD4});
        put(16'h1234, 16'd1234);
        put(16'h12A4, 16'd1234);
        // last good pulse has been counted by now
        u = nUpd;
        repeat (3) @(posedge clk_sys);
        chk("updates on bad digit", u, nUpd);
        rdchk("reject flag", ADDR_STATUS, 32'h7);
        put(16'h0009, 16'd9);
        wb(1'b1, ADDR_STATUS, 32'h1);
        rdchk("reject cleared", ADDR_STATUS, 32'h2 | 32'h4);
        $display("test reject done");
    endtask

    task automatic t_bin();
        wb(1'b1, ADDR_CTRL, {30'h0, MODE_BIN12});
        put(16'hFFFF, 16'h0FFF);
        wb(1'b1, ADDR_CTRL, {30'h0, MODE_BIN16});
        put(16'hAB65, 16'hAB65);
        wb(1'b1, ADDR_CTRL, 32'h7);
        srcLogic <= 1'b1;
        put(16'h8001, 16'h8001);
        rdchk("raw", ADDR_RAW, 32'h8001);
        $display("test binary done");
    endtask

    task automatic t_strobe();
        wb(1'b1, ADDR_TIMING, 32'h1);
        strobeOn <= 1'b1;
        put(16'h1234, 16'h1234);
        strobeOn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        u = nUpd;
        put(16'h5678, 16'h1234);
        chk("updates with strobe off", u, nUpd);
        strobeOn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("value after strobe", 32'h5678, {16'h0, setpointValue});
        $display("test strobe done");
    endtask

    task automatic t_free();
        wb(1'b1, ADDR_TIMING, 32'h0);
        strobeOn <= 1'b0;
        put(16'h4321, 16'h4321);
        wb(1'b1, ADDR_CTRL, {30'h0, MODE_BIN16});
        srcLogic <= 1'b0;
        put(16'h0F0F, 16'h0F0F);
        // clock enable low freezes the held value
        clkEn <= 1'b0;
        put(16'h1111, 16'h0F0F);
        clkEn <= 1'b1;
        put(16'h1111, 16'h1111);
        $display("test free running done");
    endtask

    initial begin
        #(40 * 3000);
        nFail++;
        $display("Error watchdog expected done seen hang");
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_bcd();
        t_reject();
        t_bin();
        t_strobe();
        t_free();
        complete_run();
    end
endmodule // dsl_setpoint_latch_tb
